/* hdl/can_msg_consts.svh */
/*
 * Offsets, field positions, reset values and limits of the CAN message buffer and filter block.
 * Assumes a byte-addressed Wishbone slave in which every register is one aligned 32-bit word.
 */
`ifndef CAN_MSG_CONSTS_SVH
`define CAN_MSG_CONSTS_SVH

`define FRAME_BYTES 13
`define NUM_TX 3

`define OFF_RECEIVER_FLAG 8'h00
`define OFF_RECEIVER_IEN 8'h04
`define OFF_TRANSMITTER_FLAG 8'h08
`define OFF_TRANSMITTER_CONTROL 8'h0C
`define OFF_ACCEPTANCE_CONTROL 8'h10
`define OFF_LOOPBACK 8'h14
`define OFF_ACCEPTANCE_PATTERN 8'h20
`define OFF_ACCEPTANCE_MASK 8'h24
`define OFF_RX_FOREGROUND 8'h40
`define OFF_TX_BUFFER 8'h80
`define TX_BUFFER_STRIDE 8'h20
`define TX_PRIORITY_WORD 4

`define RX_FULL_BIT 0
`define OVERRUN_BIT 1
`define RX_WARN_BIT 2
`define TX_WARN_BIT 3
`define RX_PASSIVE_BIT 4
`define TX_PASSIVE_BIT 5
`define BUS_OFF_BIT 6
`define WAKE_BIT 7
`define ERROR_FIELD 6:1

`define TX_EMPTY_POS 0
`define ABORT_ACK_POS 4
`define TX_IEN_POS 4
`define HIT_POS 4

`define RST_TX_EMPTY 3'h7
`define WARN_LIMIT 9'h060
`define PASSIVE_LIMIT 9'h07F
`define BUS_OFF_LIMIT 9'h0FF

`endif

/* hdl/can_msg_pkg.sv */
/*
 * Types shared by the CAN message buffer and filter block.
 * Assumes nothing of its surroundings.
 */
package can_msg_pkg;
  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_DUAL,
    MODE_QUAD,
    MODE_CLOSED
  } filt_mode_t;
  typedef logic [7:0] byte_t;
endpackage

/* hdl/can_msg_buffer_filter.sv */
/*
 * Receive queue, three prioritised transmit buffers, acceptance filter and
 * interrupt flags of a CAN controller, reached over classic Wishbone.
 * Assumes a protocol engine on the same clock that delivers frames, arbitrates,
 * reports completion and supplies error counters.
 */
`include "can_msg_consts.svh"

// Operation
// R1: Three independent transmit buffers.
// R2: Two-stage receive queue, only foreground visible.
// R3: Every message buffer holds 13 bytes.
// R4: Accepted frame copies to foreground when empty.
// R5: Host reads foreground, then clears full flag.
// R6: Both stages full: discard, flag overrun.
// R7: Background overwritten regardless of filter result.
// R8: Own frames stay in background unless loop-back.
// R9: Host fills empty buffer, clears its flag.
// R10: Successful send sets empty flag, interrupts.
// R11: Lowest local priority value sent first.
// R12: Selection repeated at every arbitration.
// R13: Abort grants only when not on bus.
// R14: Single mode compares all 32 identifier bits.
// R15: Dual mode compares two 16-bit filters.
// R16: Quad mode compares four 8-bit filters.
// R17: Mask bit set makes bit don't-care.
// R18: Lowest matching filter reported as hit.
// R19: Eleven masked sources on four outputs.
// R20: Receive interrupt right after accepted frame.
// R21: Bus activity while asleep raises wake-up.
// R22: Warning, passive and bus-off flagged separately.
// R23: Write one clears; condition keeps flag set.
// R24: Writing zero leaves a flag unchanged.
module can_msg_buffer_filter
  import can_msg_pkg::*;
#(
  parameter int NT = `NUM_TX,
  parameter int FB = `FRAME_BYTES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Frames received by the protocol engine
  input wire logic rx_done,
  input wire logic rx_own,
  input wire logic [8*FB-1:0] rx_frame,
  // Transmit arbitration with the protocol engine
  input wire logic tx_arb_req,
  input wire logic tx_on_bus,
  input wire logic tx_done,
  output logic tx_sel_valid,
  output logic [1:0] tx_sel_idx,
  output logic [8*FB-1:0] tx_frame,
  output logic loopback_en,
  // Error counters, sleep state and bus pin
  input wire logic [8:0] rx_err_cnt,
  input wire logic [8:0] tx_err_cnt,
  input wire logic sleep_state,
  input wire logic rx_pin,
  // Interrupt requests
  output logic irq_wake,
  output logic irq_error,
  output logic irq_rx,
  output logic irq_tx
);

  byte_t rx_foreground_stage_reg [FB]; // R2 R3
  byte_t rx_background_stage_reg [FB];
  byte_t tx_buffer_reg [NT][FB]; // R1
  byte_t local_priority_field_reg [NT];
  logic [7:0] receiver_flag_reg;
  logic [7:0] receiver_ien_reg;
  logic [NT-1:0] tx_empty_reg;
  logic [NT-1:0] abort_request_reg;
  logic [NT-1:0] abort_ack_reg;
  logic [NT-1:0] tx_ien_reg;
  filt_mode_t filt_mode_reg;
  logic [1:0] filter_hit_reg;
  logic [31:0] acceptance_pattern_reg;
  logic [31:0] acceptance_mask_reg;
  logic bg_valid_reg;
  logic [1:0] bg_hit_reg;
  logic rx_pin_meta_reg;
  logic rx_pin_sync_reg;

  logic wr_now;
  logic [31:0] rdata;
  logic [3:0] hits;
  logic accept;
  logic [1:0] hit_idx;
  logic copy_now;
  logic overrun_now;
  logic own_only;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic best_found;
  logic [1:0] best_idx;

  function automatic logic [7:0] word_adr(input logic [7:0] base, input int w);
    return 8'(int'(base) + 4 * w);
  endfunction

  function automatic logic [7:0] tx_base(input int i);
    return 8'(int'(`OFF_TX_BUFFER) + i * int'(`TX_BUFFER_STRIDE));
  endfunction

  // Mask bits mark don't-care positions, so they are ORed into the equality.
  function automatic logic match8(input byte_t p, input byte_t m, input byte_t x);
    return &(~(p ^ x) | m); // R17
  endfunction

  function automatic logic [1:0] lowest_hit(input logic [3:0] h);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (h[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  function automatic logic reg_wr(input logic [7:0] adr, input logic [7:0] off);
    return wr_now && (adr == off) && wb_sel_i[0];
  endfunction

  // Writes land on the edge at which the master sees ack, so a stalled master
  // never commits a write twice.
  assign wr_now = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        wb_dat_o <= rdata;
      end
    end
  end

  // Unmapped addresses read as zero and still acknowledge.
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (wb_adr_i)
      `OFF_RECEIVER_FLAG: rdata[7:0] = receiver_flag_reg;
      `OFF_RECEIVER_IEN: rdata[7:0] = receiver_ien_reg;
      `OFF_TRANSMITTER_FLAG: begin
        rdata[`TX_EMPTY_POS+:NT] = tx_empty_reg;
        rdata[`ABORT_ACK_POS+:NT] = abort_ack_reg;
      end
      `OFF_TRANSMITTER_CONTROL: begin
        rdata[NT-1:0] = abort_request_reg;
        rdata[`TX_IEN_POS+:NT] = tx_ien_reg;
      end
      `OFF_ACCEPTANCE_CONTROL: begin
        rdata[1:0] = filt_mode_reg;
        rdata[`HIT_POS+:2] = filter_hit_reg;
      end
      `OFF_LOOPBACK: rdata[0] = loopback_en;
      `OFF_ACCEPTANCE_PATTERN: rdata = acceptance_pattern_reg;
      `OFF_ACCEPTANCE_MASK: rdata = acceptance_mask_reg;
      default: ;
    endcase
    for (int w = 0; w < 4; w++) begin
      for (int l = 0; l < 4; l++) begin
        if (4 * w + l < FB) begin
          if (wb_adr_i == word_adr(`OFF_RX_FOREGROUND, w)) begin
            rdata[8*l+:8] = rx_foreground_stage_reg[4*w+l]; // R2
          end
          for (int i = 0; i < NT; i++) begin
            if (wb_adr_i == word_adr(tx_base(i), w)) begin
              rdata[8*l+:8] = tx_buffer_reg[i][4*w+l];
            end
          end
        end
      end
    end
    for (int i = 0; i < NT; i++) begin
      if (wb_adr_i == word_adr(tx_base(i), `TX_PRIORITY_WORD)) begin
        rdata[7:0] = local_priority_field_reg[i];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      receiver_ien_reg <= 8'h00;
      tx_ien_reg <= '0;
      filt_mode_reg <= MODE_SINGLE;
      loopback_en <= 1'b0;
      acceptance_pattern_reg <= 32'h0000_0000;
      acceptance_mask_reg <= 32'h0000_0000;
    end else begin
      if (reg_wr(wb_adr_i, `OFF_RECEIVER_IEN)) begin
        receiver_ien_reg <= wb_dat_i[7:0];
      end
      if (reg_wr(wb_adr_i, `OFF_TRANSMITTER_CONTROL)) begin
        tx_ien_reg <= wb_dat_i[`TX_IEN_POS+:NT];
      end
      if (reg_wr(wb_adr_i, `OFF_ACCEPTANCE_CONTROL)) begin
        filt_mode_reg <= filt_mode_t'(wb_dat_i[1:0]);
      end
      if (reg_wr(wb_adr_i, `OFF_LOOPBACK)) begin
        loopback_en <= wb_dat_i[0];
      end
      for (int l = 0; l < 4; l++) begin
        if (wr_now && wb_sel_i[l] && wb_adr_i == `OFF_ACCEPTANCE_PATTERN) begin
          acceptance_pattern_reg[8*l+:8] <= wb_dat_i[8*l+:8];
        end
        if (wr_now && wb_sel_i[l] && wb_adr_i == `OFF_ACCEPTANCE_MASK) begin
          acceptance_mask_reg[8*l+:8] <= wb_dat_i[8*l+:8];
        end
      end
    end
  end

  // Buffer contents are data, so they carry no reset.
  always_ff @(posedge clock) begin
    for (int i = 0; i < NT; i++) begin
      for (int w = 0; w < 4; w++) begin
        for (int l = 0; l < 4; l++) begin
          if (4 * w + l < FB && wr_now && wb_sel_i[l] &&
              wb_adr_i == word_adr(tx_base(i), w)) begin
            tx_buffer_reg[i][4*w+l] <= wb_dat_i[8*l+:8]; // R9
          end
        end
      end
      if (wr_now && wb_sel_i[0] &&
          wb_adr_i == word_adr(tx_base(i), `TX_PRIORITY_WORD)) begin
        local_priority_field_reg[i] <= wb_dat_i[7:0];
      end
    end
  end

  always_comb begin
    logic [7:0] id [4];
    logic [7:0] p [4];
    logic [7:0] m [4];
    for (int k = 0; k < 4; k++) begin
      id[k] = rx_frame[8*k+:8];
      p[k] = acceptance_pattern_reg[8*k+:8];
      m[k] = acceptance_mask_reg[8*k+:8];
    end
    unique case (filt_mode_reg)
      MODE_SINGLE: hits = {3'h0, match8(p[0], m[0], id[0]) && match8(p[1], m[1], id[1]) &&
                           match8(p[2], m[2], id[2]) && match8(p[3], m[3], id[3])}; // R14
      MODE_DUAL: hits = {2'h0,
                         match8(p[2], m[2], id[0]) && match8(p[3], m[3], id[1]),
                         match8(p[0], m[0], id[0]) && match8(p[1], m[1], id[1])}; // R15
      MODE_QUAD: hits = {match8(p[3], m[3], id[0]), match8(p[2], m[2], id[0]),
                         match8(p[1], m[1], id[0]), match8(p[0], m[0], id[0])}; // R16
      MODE_CLOSED: hits = 4'h0;
    endcase
  end

  assign accept = |hits;
  assign hit_idx = lowest_hit(hits); // R18
  assign own_only = rx_own && !loopback_en; // R8
  assign copy_now = bg_valid_reg && !receiver_flag_reg[`RX_FULL_BIT]; // R4
  assign overrun_now = rx_done && !own_only && bg_valid_reg &&
                       receiver_flag_reg[`RX_FULL_BIT]; // R6

  // A pending message in the background stage is protected only while the
  // foreground is full; otherwise it is copied on the same edge it is replaced.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bg_valid_reg <= 1'b0;
      bg_hit_reg <= 2'h0;
    end else if (rx_done && !(bg_valid_reg && receiver_flag_reg[`RX_FULL_BIT])) begin
      bg_valid_reg <= accept && !own_only; // R7 R8
      bg_hit_reg <= hit_idx;
    end else if (copy_now) begin
      bg_valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    for (int b = 0; b < FB; b++) begin
      if (rx_done && !(bg_valid_reg && receiver_flag_reg[`RX_FULL_BIT])) begin
        rx_background_stage_reg[b] <= rx_frame[8*b+:8]; // R7
      end
      if (copy_now) begin
        rx_foreground_stage_reg[b] <= rx_background_stage_reg[b]; // R4
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      filter_hit_reg <= 2'h0;
    end else if (copy_now) begin
      filter_hit_reg <= bg_hit_reg; // R18
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_pin_meta_reg <= 1'b1;
      rx_pin_sync_reg <= 1'b1;
    end else begin
      rx_pin_meta_reg <= rx_pin;
      rx_pin_sync_reg <= rx_pin_meta_reg;
    end
  end

  // Error and wake sources are levels: a flag that is cleared while its cause holds sets again
  // on the same edge, and a set always wins over a clear.
  always_comb begin
    flag_set = 8'h00;
    flag_set[`RX_FULL_BIT] = copy_now; // R4
    flag_set[`OVERRUN_BIT] = overrun_now; // R6
    flag_set[`RX_WARN_BIT] = rx_err_cnt >= `WARN_LIMIT; // R22
    flag_set[`TX_WARN_BIT] = tx_err_cnt >= `WARN_LIMIT; // R22
    flag_set[`RX_PASSIVE_BIT] = rx_err_cnt > `PASSIVE_LIMIT; // R22
    flag_set[`TX_PASSIVE_BIT] = tx_err_cnt > `PASSIVE_LIMIT; // R22
    flag_set[`BUS_OFF_BIT] = tx_err_cnt > `BUS_OFF_LIMIT; // R22
    flag_set[`WAKE_BIT] = sleep_state && !rx_pin_sync_reg; // R21
    flag_clr = reg_wr(wb_adr_i, `OFF_RECEIVER_FLAG) ? wb_dat_i[7:0] : 8'h00; // R5 R23
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      receiver_flag_reg <= 8'h00;
    end else begin
      receiver_flag_reg <= (receiver_flag_reg & ~flag_clr) | flag_set; // R23 R24
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_empty_reg <= `RST_TX_EMPTY;
      abort_request_reg <= '0;
      abort_ack_reg <= '0;
    end else begin
      for (int i = 0; i < NT; i++) begin
        logic done_i;
        logic abort_ok;
        done_i = tx_done && tx_sel_valid && tx_sel_idx == 2'(i);
        abort_ok = abort_request_reg[i] && !tx_empty_reg[i] &&
                   !(tx_on_bus && tx_sel_idx == 2'(i)); // R13
        if (done_i || abort_ok) begin
          tx_empty_reg[i] <= 1'b1; // R10 R13
          abort_request_reg[i] <= 1'b0;
          abort_ack_reg[i] <= abort_ok && !done_i; // R13
        end else begin
          if (reg_wr(wb_adr_i, `OFF_TRANSMITTER_FLAG) && wb_dat_i[`TX_EMPTY_POS+i]) begin
            tx_empty_reg[i] <= 1'b0; // R9 R23
            abort_ack_reg[i] <= 1'b0;
          end
          if (reg_wr(wb_adr_i, `OFF_TRANSMITTER_CONTROL) && wb_dat_i[i] && !tx_empty_reg[i]) begin
            abort_request_reg[i] <= 1'b1; // R13
          end
        end
      end
    end
  end

  // Ties go to the lower-numbered buffer.
  always_comb begin
    best_found = 1'b0;
    best_idx = 2'h0;
    for (int i = 0; i < NT; i++) begin
      if (!tx_empty_reg[i] &&
          (!best_found || local_priority_field_reg[i] < local_priority_field_reg[best_idx])) begin
        best_found = 1'b1; // R11
        best_idx = 2'(i);
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_sel_valid <= 1'b0;
      tx_sel_idx <= 2'h0;
      tx_frame <= '0;
    end else if (tx_arb_req) begin
      tx_sel_valid <= best_found; // R12
      tx_sel_idx <= best_idx;
      for (int b = 0; b < FB; b++) begin
        tx_frame[8*b+:8] <= tx_buffer_reg[best_idx][b];
      end
    end else if (tx_done || tx_empty_reg[tx_sel_idx]) begin
      tx_sel_valid <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_wake <= 1'b0;
      irq_error <= 1'b0;
      irq_rx <= 1'b0;
      irq_tx <= 1'b0;
    end else begin
      irq_wake <= receiver_flag_reg[`WAKE_BIT] && receiver_ien_reg[`WAKE_BIT]; // R19 R21
      irq_error <= |(receiver_flag_reg[`ERROR_FIELD] & receiver_ien_reg[`ERROR_FIELD]); // R19
      irq_rx <= receiver_flag_reg[`RX_FULL_BIT] && receiver_ien_reg[`RX_FULL_BIT]; // R20
      irq_tx <= |(tx_empty_reg & tx_ien_reg); // R10 R19
    end
  end

  logic sel_is_min;
  always_comb begin
    sel_is_min = 1'b1;
    for (int i = 0; i < NT; i++) begin
      if (!tx_empty_reg[i] && local_priority_field_reg[i] < local_priority_field_reg[tx_sel_idx]) begin
        sel_is_min = 1'b0;
      end
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_copy_sets_full: assert property ( // R4
    copy_now |=> receiver_flag_reg[`RX_FULL_BIT] &&
      rx_foreground_stage_reg[0] == $past(rx_background_stage_reg[0]))
    else $error("copy did not set the full flag");
  a_overrun_discard: assert property ( // R6
    overrun_now |=> receiver_flag_reg[`OVERRUN_BIT] && bg_valid_reg &&
      rx_background_stage_reg[0] == $past(rx_background_stage_reg[0]))
    else $error("overrun frame kept");
  a_own_no_copy: assert property ( // R8
    (rx_done && own_only && !receiver_flag_reg[`RX_FULL_BIT]) |=> !bg_valid_reg ##1
      !$rose(receiver_flag_reg[`RX_FULL_BIT]))
    else $error("own frame reached the foreground");
  a_done_sets_empty: assert property ( // R10
    (tx_done && tx_sel_valid) |=> tx_empty_reg[$past(tx_sel_idx)] &&
      !abort_ack_reg[$past(tx_sel_idx)])
    else $error("sent buffer not marked empty");
  a_arb_lowest: assert property ( // R11 R12
    (tx_arb_req && best_found) |=> tx_sel_valid && sel_is_min)
    else $error("selection is not the lowest priority");
  a_abort_off_bus: assert property ( // R13
    (tx_on_bus && tx_sel_valid) |=> !$rose(abort_ack_reg[$past(tx_sel_idx)]))
    else $error("abort granted while on the bus");
  a_busoff_holds: assert property ( // R22 R23
    (tx_err_cnt > `BUS_OFF_LIMIT) [*2] |-> receiver_flag_reg[`BUS_OFF_BIT])
    else $error("bus-off flag lost");
  a_clear_by_one: assert property ( // R23 R24
    $fell(receiver_flag_reg[`RX_FULL_BIT]) |-> $past(flag_clr[`RX_FULL_BIT]))
    else $error("full flag cleared without a one written");
  a_rx_irq_timing: assert property ( // R20
    (copy_now && receiver_ien_reg[`RX_FULL_BIT]) |=> ##1 irq_rx)
    else $error("receive interrupt late");
  a_wake_flag: assert property ( // R21
    (sleep_state && !rx_pin_sync_reg) |=> receiver_flag_reg[`WAKE_BIT])
    else $error("wake-up activity not flagged");

endmodule

/* dv/can_engine_model.sv */
/*
 * Protocol engine model: offers received frames, arbitrates, reports sends, drives counters.
 * Assumes the block's clock and a bench that calls one task at a time.
 */
module can_engine_model (
  // Clock
  input wire logic clock,
  // Received frames
  output logic rx_done,
  output logic rx_own,
  output logic [103:0] rx_frame,
  // Transmit arbitration
  output logic tx_arb_req,
  output logic tx_on_bus,
  output logic tx_done,
  input wire logic tx_sel_valid,
  // Counters, sleep state and bus pin
  output logic [8:0] rx_err_cnt,
  output logic [8:0] tx_err_cnt,
  output logic sleep_state,
  output logic rx_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    rx_done = 1'b0;
    rx_own = 1'b0;
    rx_frame = '0;
    tx_arb_req = 1'b0;
    tx_on_bus = 1'b0;
    tx_done = 1'b0;
    rx_err_cnt = 9'h000;
    tx_err_cnt = 9'h000;
    sleep_state = 1'b0;
    rx_pin = 1'b1;
  end

  // A frame is offered after end of frame, then inverted so stale data stands out.
  task automatic send(input logic [103:0] f, input logic own);
    @(posedge clock);
    rx_done <= 1'b1;
    rx_own <= own;
    rx_frame <= f;
    @(posedge clock);
    rx_done <= 1'b0;
    rx_own <= ~own;
    rx_frame <= ~f;
    repeat (3) @(posedge clock);
  endtask

  // Called for every arbitration, retries included.
  task automatic arb(input logic on);
    @(posedge clock);
    tx_arb_req <= 1'b1;
    @(posedge clock);
    tx_arb_req <= 1'b0;
    tx_on_bus <= on;
    @(posedge clock);
  endtask

  task automatic done();
    @(posedge clock);
    if (tx_sel_valid === 1'b1) begin
      tx_done <= 1'b1;
      @(posedge clock);
      tx_done <= 1'b0;
      tx_on_bus <= 1'b0;
    end
    repeat (3) @(posedge clock);
  endtask

  task automatic errs(input logic [8:0] r, input logic [8:0] t);
    @(posedge clock);
    rx_err_cnt <= r;
    tx_err_cnt <= t;
    repeat (4) @(posedge clock);
  endtask

  // A dominant pin during sleep is the bus activity that wakes the node.
  task automatic wake(input logic s, input logic p);
    @(posedge clock);
    sleep_state <= s;
    rx_pin <= p;
    repeat (6) @(posedge clock);
  endtask
endmodule

/* dv/can_msg_buffer_filter_tb_top.sv */
/*
 * Self-checking bench of the message block: Wishbone host, engine model, monitor.
 * Assumes the block acknowledges every Wishbone access.
 */
`include "can_msg_consts.svh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
module can_msg_buffer_filter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, rst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic wb_ack_o, probe = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic rx_done, rx_own, tx_arb_req, tx_on_bus, tx_done, tx_sel_valid, loopback_en;
  logic [103:0] rx_frame, tx_frame;
  logic [1:0] tx_sel_idx;
  logic [8:0] rx_err_cnt, tx_err_cnt;
  logic sleep_state, rx_pin, irq_wake, irq_error, irq_rx, irq_tx;
  logic [39:0] expq[$], mskq[$], mon_exp, mon_msk;
  logic [7:0] pr [3];
  logic [8:0] rc [8] = '{9'h05F, 9'h060, 9'h07F, 9'h080, 9'h000, 9'h000, 9'h000, 9'h1FF};
  logic [8:0] tc [8] = '{9'h000, 9'h000, 9'h07F, 9'h000, 9'h060, 9'h080, 9'h0FF, 9'h100};
  int error_cnt, compares;
  wire logic [39:0] port_vec = {tx_frame[31:0], tx_sel_valid, tx_sel_idx, irq_wake, irq_error,
    irq_rx, irq_tx, loopback_en};

  can_msg_buffer_filter can_msg_buffer_filter_inst (.clock, .rst_n, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_done, .rx_own,
    .rx_frame, .tx_arb_req, .tx_on_bus, .tx_done, .tx_sel_valid, .tx_sel_idx, .tx_frame,
    .loopback_en, .rx_err_cnt, .tx_err_cnt, .sleep_state, .rx_pin, .irq_wake, .irq_error,
    .irq_rx, .irq_tx);
  can_engine_model can_engine_model_inst (.clock, .rx_done, .rx_own, .rx_frame, .tx_arb_req,
    .tx_on_bus, .tx_done, .tx_sel_valid, .rx_err_cnt, .tx_err_cnt, .sleep_state, .rx_pin);

  always #10 clock = ~clock;

  // The oldest note belongs to the next result, since the drivers never overlap.
  always @(posedge clock) begin
    if (probe || (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i)) begin
      mon_exp = expq.pop_front();
      mon_msk = mskq.pop_front();
      if (probe)
        `CHK(port_vec & mon_msk, mon_exp & mon_msk)
      else
        `CHK({8'h00, wb_dat_o} & mon_msk, mon_exp & mon_msk)
    end
  end

  task automatic close_out();
    if (error_cnt == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50)
      error_cnt++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back({8'h00, e});
    mskq.push_back(40'h00_FFFF_FFFF);
    wb(1'b0, a, $urandom);
  endtask

  task automatic chk(input logic [39:0] e, input logic [39:0] m);
    @(posedge clock);
    expq.push_back(e);
    mskq.push_back(m);
    probe <= 1'b1;
    @(posedge clock);
    probe <= 1'b0;
  endtask

  // Returns {accepted, hit}; the lowest matching filter wins.
  function automatic logic [2:0] filt(input logic [1:0] m, input logic [31:0] id,
    input logic [31:0] p, input logic [31:0] k);
    logic [3:0] h = 4'h0;
    logic [1:0] hit = 2'd0;
    if (m == 2'd0)
      h[0] = ((id ^ p) & ~k) == 32'h0;
    for (int i = 0; i < 4; i++) begin
      if (m == 2'd1 && i < 2)
        h[i] = ((id[15:0] ^ p[16*i+:16]) & ~k[16*i+:16]) == 16'h0;
      if (m == 2'd2)
        h[i] = ((id[7:0] ^ p[8*i+:8]) & ~k[8*i+:8]) == 8'h00;
    end
    for (int i = 3; i >= 0; i--)
      if (h[i])
        hit = 2'(i);
    return {|h, hit};
  endfunction

  function automatic logic [1:0] best(input logic [2:0] pend);
    logic [1:0] b;
    logic [8:0] lo;
    lo = 9'h100;
    b = 2'd0;
    for (int i = 0; i < 3; i++)
      if (pend[i] && {1'b0, pr[i]} < lo) begin
        lo = {1'b0, pr[i]};
        b = 2'(i);
      end
    return b;
  endfunction

  initial begin
    #200_000;
    error_cnt++;
    close_out();
  end

  initial begin
    logic [31:0] p, k, id, id_t [3];
    logic [103:0] f, fr [3];
    logic [2:0] fh, pend;
    logic [1:0] e, j;
    logic [6:0] fl;
    void'($urandom(32'h3f1e));
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    rd(`OFF_RECEIVER_FLAG, 32'h0);
    rd(`OFF_TRANSMITTER_FLAG, 32'h7);
    rd(`OFF_ACCEPTANCE_CONTROL, 32'h0);
    wr(8'h3C, $urandom);
    rd(8'h3C, 32'h0);
    wr(`OFF_RECEIVER_IEN, 32'h1);
    for (int i = 0; i < 16; i++) begin
      id = $urandom;
      k = $urandom & $urandom;
      case (i % 4)
        1: p = {2{id[15:0]}};
        2: p = {4{id[7:0]}};
        default: p = id;
      endcase
      p = p ^ ($urandom & $urandom & $urandom);
      f = {8'($urandom), $urandom, $urandom, id};
      fh = filt(2'(i), id, p, k);
      wr(`OFF_ACCEPTANCE_CONTROL, 32'(i % 4));
      wr(`OFF_ACCEPTANCE_PATTERN, p);
      wr(`OFF_ACCEPTANCE_MASK, k);
      can_engine_model_inst.send(f, 1'b0);
      chk({37'h0, fh[2], 2'b00}, 40'hFF);
      rd(`OFF_RECEIVER_FLAG, {31'h0, fh[2]});
      if (fh[2]) begin
        rd(`OFF_RX_FOREGROUND, id);
        rd(8'h4C, {24'h0, f[103:96]});
        rd(`OFF_ACCEPTANCE_CONTROL, {26'h0, fh[1:0], 2'b00, 2'(i)});
        wr(`OFF_RECEIVER_FLAG, 32'h1);
      end
    end
    wr(`OFF_ACCEPTANCE_CONTROL, 32'h0);
    wr(`OFF_ACCEPTANCE_MASK, 32'hFFFF_FFFF);
    wr(`OFF_RECEIVER_IEN, 32'h3);
    for (int i = 0; i < 3; i++) begin
      fr[i] = {8'($urandom), $urandom, $urandom, $urandom};
      can_engine_model_inst.send(fr[i], 1'b0);
    end
    rd(`OFF_RX_FOREGROUND, fr[0][31:0]);
    rd(`OFF_RECEIVER_FLAG, 32'h3);
    chk(40'h0C, 40'hFF);
    wr(`OFF_RECEIVER_FLAG, 32'h1);
    repeat (3) @(posedge clock);
    rd(`OFF_RX_FOREGROUND, fr[1][31:0]);
    rd(`OFF_RECEIVER_FLAG, 32'h3);
    wr(`OFF_RECEIVER_FLAG, 32'h2);
    rd(`OFF_RECEIVER_FLAG, 32'h1);
    wr(`OFF_RECEIVER_FLAG, 32'h1);
    can_engine_model_inst.send(fr[2], 1'b1);
    rd(`OFF_RECEIVER_FLAG, 32'h0);
    wr(`OFF_LOOPBACK, 32'h1);
    chk(40'h01, 40'hFF);
    can_engine_model_inst.send(fr[2], 1'b1);
    rd(`OFF_RX_FOREGROUND, fr[2][31:0]);
    wr(`OFF_RECEIVER_FLAG, 32'h1);
    wr(`OFF_LOOPBACK, 32'h0);
    wr(`OFF_TRANSMITTER_CONTROL, 32'h70);
    for (int i = 0; i < 3; i++) begin
      id_t[i] = $urandom;
      pr[i] = 8'($urandom) & 8'h07;
      wr(8'(`OFF_TX_BUFFER + `TX_BUFFER_STRIDE * i), id_t[i]);
      wr(8'(`OFF_TX_BUFFER + `TX_BUFFER_STRIDE * i + 4 * `TX_PRIORITY_WORD), {24'h0, pr[i]});
    end
    wr(`OFF_TRANSMITTER_FLAG, 32'h7);
    rd(`OFF_TRANSMITTER_FLAG, 32'h0);
    pend = 3'b111;
    for (int n = 0; n < 4; n++) begin
      can_engine_model_inst.arb(1'b0);
      e = best(pend);
      chk({id_t[e], 1'b1, e, 3'b000, pend != 3'b111, 1'b0}, 40'hFF_FFFF_FFFF);
      if (n == 0) begin
        j = (e == 2'd2) ? 2'd0 : e + 2'd1;
        pr[j] = 8'h00;
        wr(8'(`OFF_TX_BUFFER + `TX_BUFFER_STRIDE * j + 4 * `TX_PRIORITY_WORD), 32'h0);
      end else begin
        can_engine_model_inst.done();
        pend[e] = 1'b0;
        rd(`OFF_TRANSMITTER_FLAG, {29'h0, ~pend});
        chk(40'h02, 40'h9F);
      end
    end
    wr(`OFF_TRANSMITTER_FLAG, 32'h1);
    wr(`OFF_TRANSMITTER_CONTROL, 32'h71);
    repeat (3) @(posedge clock);
    rd(`OFF_TRANSMITTER_FLAG, 32'h17);
    wr(`OFF_TRANSMITTER_FLAG, 32'h2);
    can_engine_model_inst.arb(1'b1);
    wr(`OFF_TRANSMITTER_CONTROL, 32'h72);
    rd(`OFF_TRANSMITTER_FLAG, 32'h15);
    can_engine_model_inst.done();
    rd(`OFF_TRANSMITTER_FLAG, 32'h17);
    wr(`OFF_RECEIVER_IEN, 32'h7C);
    for (int i = 0; i < 8; i++) begin
      can_engine_model_inst.errs(rc[i], tc[i]);
      fl = {tc[i] > 9'h0FF, tc[i] > 9'h07F, rc[i] > 9'h07F, tc[i] >= 9'h060, rc[i] >= 9'h060,
        2'b00};
      rd(`OFF_RECEIVER_FLAG, {25'h0, fl});
      chk({36'h0, |fl, 3'b000}, 40'h08);
      wr(`OFF_RECEIVER_FLAG, 32'h7C);
      rd(`OFF_RECEIVER_FLAG, {25'h0, fl});
      can_engine_model_inst.errs(9'h000, 9'h000);
      wr(`OFF_RECEIVER_FLAG, 32'h7C);
      rd(`OFF_RECEIVER_FLAG, 32'h0);
    end
    wr(`OFF_RECEIVER_IEN, 32'h0);
    can_engine_model_inst.wake(1'b1, 1'b0);
    chk(40'h00, 40'h10);
    wr(`OFF_RECEIVER_IEN, 32'h80);
    chk(40'h10, 40'h10);
    rd(`OFF_RECEIVER_FLAG, 32'h80);
    can_engine_model_inst.wake(1'b0, 1'b1);
    wr(`OFF_RECEIVER_FLAG, 32'h80);
    rd(`OFF_RECEIVER_FLAG, 32'h0);
    close_out();
  end
endmodule
